// *** rtl/urx_pkg.sv ***
package urx_pkg;
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_DATA     = 8'h04;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h08;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h0C;
    localparam logic [7:0] ADDR_BAUD     = 8'h10;
    localparam logic [7:0] ADDR_IRQCTL   = 8'h14;
    localparam int SB_PE = 0, SB_FE = 1, SB_NF = 2, SB_OVR = 3;
    localparam int SB_RIDLE = 4, SB_RDY = 5, SB_TIDLE = 6, SB_TEMPTY = 7;
    localparam int C1_EN = 0, C1_NINE = 1, C1_PEN = 2, C1_ODD = 3, C1_TWO = 4, C1_RX8 = 5;
    localparam int C2_RECEIVER_ENABLE = 0, C2_ADDR_DETECT_ENABLE = 1, C2_RIE = 2, C2_TEIE = 3, C2_TIIE = 4;
    localparam int C2_WAKE = 5;
    localparam int IC_GIE = 0, IC_UIE = 1;
    localparam logic [7:0] BAUD_RST      = 8'h00;
    localparam logic [3:0] OS_FIRST      = 4'h7;
    localparam logic [3:0] OS_LAST       = 4'h9;
    localparam logic [3:0] OS_END        = 4'hF;
    localparam logic [3:0] LAST_BIT_NINE = 4'h8;
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [1:0] FIFO_DEPTH    = 2'h2;
    localparam int WAKE_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] WAKE_CYC = 8'(WAKE_DELAY_NS / CLK_PERIOD_NS);

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_DATA  = 6'h04,
        ST_PAR   = 6'h08,
        ST_STOP1 = 6'h10,
        ST_STOP2 = 6'h20
    } urx_rx_st_t;

    typedef struct packed {
        logic [8:0] data;
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic       nf;
    } urx_entry_t;

    typedef struct packed {
        urx_rx_st_t       rx_st;
        logic [7:0]       tick_cnt;
        logic [3:0]       os_cnt;
        logic [2:0]       samp;
        logic [3:0]       bit_cnt;
        logic [8:0]       shift;
        logic             par_bit;
        logic             nf;
        logic             framing_error_flag;
        logic             rx_prev;
        urx_entry_t [1:0] fifo;
        logic             head;
        logic [1:0]       count;
        logic             overrun;
        logic             armed;
        logic [4:0]       ctrl_one;
        logic [5:0]       ctrl_two;
        logic [7:0]       baud;
        logic [1:0]       irqctl;
        logic             waking;
        logic [7:0]       wake_cnt;
        logic             tx_empty_prev;
        logic             tx_idle_prev;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq_n;
        logic             wake_req;
    } urx_state_t;
endpackage

// *** rtl/urx_rx_err.sv ***
`timescale 1ns/100ps
module urx_rx_err
    import urx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    input  wire logic        uart_clk_on,
    input  wire logic        tx_buf_empty,
    input  wire logic        tx_idle,
    output logic             uart_irq_n,
    output logic             wake_req
);
    urx_state_t st;
    urx_state_t nx;
    logic        rx_enabled;
    logic        tick;
    logic        samp_end;
    logic        bitv;
    logic        bit_noisy;
    logic        frame_done;
    logic        fe_in;
    logic        pe_in;
    logic        nf_in;
    logic        top_bit;
    logic [8:0]  word;
    logic        push;
    logic        pop;
    logic        seq_clear;
    logic        ovr_set;
    logic        rx_evt;
    logic        any_evt;
    logic        wake_trig;
    logic        wake_done;
    logic        apb_acc;
    logic        tail;
    logic [31:0] rd_val;
    logic        rd_err;

    assign prdata     = st.prdata;
    assign pready     = st.pready;
    assign pslverr    = st.pslverr;
    assign uart_irq_n = st.irq_n;
    assign wake_req   = st.wake_req;

    always_comb
    begin
        nx         = st;
        tick       = 1'b0;
        samp_end   = 1'b0;
        frame_done = 1'b0;
        push       = 1'b0;
        pop        = 1'b0;
        seq_clear  = 1'b0;
        ovr_set    = 1'b0;
        rx_evt     = 1'b0;
        wake_trig  = 1'b0;
        wake_done  = 1'b0;
        rd_val     = 32'h0000_0000;
        rd_err     = 1'b0;
        bitv       = (st.samp[0] & st.samp[1]) | (st.samp[0] & st.samp[2])
                   | (st.samp[1] & st.samp[2]);
        bit_noisy  = !((st.samp[0] == st.samp[1]) && (st.samp[1] == st.samp[2]));
        word       = st.ctrl_one[C1_NINE] ? st.shift : {1'b0, st.shift[7:0]};
        top_bit    = st.ctrl_one[C1_NINE] ? word[8] : word[7];
        fe_in      = st.framing_error_flag | !bitv;
        nf_in      = st.nf | bit_noisy;
        pe_in      = st.ctrl_one[C1_PEN] & ((^word ^ st.par_bit) != st.ctrl_one[C1_ODD]);
        tail       = (st.count == 2'h1) ? ~st.head : st.head;
        apb_acc    = psel & penable & st.pready;
        nx.pready  = 1'b0;
        nx.pslverr = 1'b0;
        nx.irq_n   = 1'b1;
        nx.wake_req = 1'b0;
        nx.rx_prev = rxd;
        nx.tx_empty_prev = tx_buf_empty;
        nx.tx_idle_prev  = tx_idle;

        // Register read mux; the PE, FE and NF status flags reflect the word at the head
        case (paddr)
            ADDR_STATUS:
            begin
                rd_val[SB_PE]     = (st.count != 2'h0) & st.fifo[st.head].parity_error_flag;
                rd_val[SB_FE]     = (st.count != 2'h0) & st.fifo[st.head].framing_error_flag;
                rd_val[SB_NF]     = (st.count != 2'h0) & st.fifo[st.head].nf;
                rd_val[SB_OVR]    = st.overrun;
                rd_val[SB_RIDLE]  = (st.rx_st == ST_IDLE);
                rd_val[SB_RDY]    = (st.count != 2'h0);
                rd_val[SB_TIDLE]  = tx_idle;
                rd_val[SB_TEMPTY] = tx_buf_empty;
            end
            ADDR_DATA:     rd_val[8:0] = st.fifo[st.head].data;
            ADDR_CTRL_ONE:
            begin
                rd_val[4:0]    = st.ctrl_one;
                rd_val[C1_RX8] = st.fifo[st.head].data[8];
            end
            ADDR_CTRL_TWO: rd_val[5:0] = st.ctrl_two;
            ADDR_BAUD:     rd_val[7:0] = st.baud;
            ADDR_IRQCTL:   rd_val[1:0] = st.irqctl;
            default:       rd_err = 1'b1;
        endcase

        // APB: zero wait states, data captured in the setup cycle
        if (psel && !penable)
        begin
            nx.pready  = 1'b1;
            nx.prdata  = pwrite ? 32'h0000_0000 : rd_val;
            nx.pslverr = rd_err;
        end
        // Status flags have no write path
        if (apb_acc && pwrite)
        begin
            case (paddr)
                ADDR_CTRL_ONE: nx.ctrl_one = pwdata[4:0];
                ADDR_CTRL_TWO: nx.ctrl_two = pwdata[5:0];
                ADDR_BAUD:     nx.baud     = pwdata[7:0];
                ADDR_IRQCTL:   nx.irqctl   = pwdata[1:0];
                default:       nx.armed    = st.armed;
            endcase
        end
        if (apb_acc && !pwrite && paddr == ADDR_STATUS)
            nx.armed = 1'b1;
        if (apb_acc && !pwrite && paddr == ADDR_DATA && st.armed)
        begin
            seq_clear = 1'b1;
            nx.armed  = 1'b0;
            pop       = (st.count != 2'h0);
        end

        // Receiver; holds its place while the source clock is stopped
        rx_enabled = st.ctrl_one[C1_EN] & st.ctrl_two[C2_RECEIVER_ENABLE] & !st.waking;
        if (!rx_enabled)
        begin
            nx.rx_st    = ST_IDLE;
            nx.tick_cnt = 8'h00;
        end
        else if (uart_clk_on)
        begin
            if (st.rx_st == ST_IDLE)
            begin
                nx.tick_cnt = 8'h00;
                nx.os_cnt   = 4'h0;
                if (st.rx_prev && !rxd)
                begin
                    nx.rx_st   = ST_START;
                    nx.nf      = 1'b0;
                    nx.framing_error_flag    = 1'b0;
                    nx.bit_cnt = 4'h0;
                end
            end
            else
            begin
                tick = (st.tick_cnt == st.baud);
                nx.tick_cnt = tick ? 8'h00 : st.tick_cnt + 8'h01;
            end
        end
        if (tick)
        begin
            nx.os_cnt = st.os_cnt + 4'h1;
            if (st.os_cnt >= OS_FIRST && st.os_cnt <= OS_LAST)
                nx.samp = {st.samp[1:0], rxd};
            samp_end = (st.os_cnt == OS_END);
        end
        if (samp_end)
        begin
            nx.nf = nf_in;
            case (st.rx_st)
                ST_START:
                    nx.rx_st = bitv ? ST_IDLE : ST_DATA;
                ST_DATA:
                begin
                    nx.shift[st.bit_cnt] = bitv;
                    nx.bit_cnt = st.bit_cnt + 4'h1;
                    if (st.bit_cnt == (st.ctrl_one[C1_NINE] ? LAST_BIT_NINE : LAST_BIT_EIGHT))
                        nx.rx_st = st.ctrl_one[C1_PEN] ? ST_PAR : ST_STOP1;
                end
                ST_PAR:
                begin
                    nx.par_bit = bitv;
                    nx.rx_st   = ST_STOP1;
                end
                ST_STOP1:
                begin
                    nx.framing_error_flag = fe_in;
                    if (st.ctrl_one[C1_TWO])
                        nx.rx_st = ST_STOP2;
                    else
                    begin
                        nx.rx_st   = ST_IDLE;
                        frame_done = 1'b1;
                    end
                end
                ST_STOP2:
                begin
                    nx.rx_st   = ST_IDLE;
                    frame_done = 1'b1;
                end
                default: nx.rx_st = ST_IDLE;
            endcase
        end

        // Two-entry buffer; a full buffer not read in the same cycle drops the new word and flags it
        if (frame_done)
        begin
            if (st.count < FIFO_DEPTH || pop)
            begin
                push = 1'b1;
                nx.fifo[tail] = '{data: word, framing_error_flag: fe_in, parity_error_flag: pe_in, nf: nf_in};
            end
            else
                ovr_set = 1'b1;
        end
        if (pop)
            nx.head = ~st.head;
        nx.count   = st.count + {1'b0, push} - {1'b0, pop};
        nx.overrun = (st.overrun & !seq_clear) | ovr_set;

        // Receive-pin wake-up with restart delay
        wake_trig = !uart_clk_on & st.ctrl_two[C2_WAKE] & st.ctrl_one[C1_EN]
                  & st.ctrl_two[C2_RECEIVER_ENABLE] & st.ctrl_two[C2_RIE]
                  & st.rx_prev & !rxd & !st.waking;
        if (wake_trig)
        begin
            nx.waking   = 1'b1;
            nx.wake_cnt = WAKE_CYC;
            nx.wake_req = 1'b1;
        end
        else if (st.waking)
        begin
            if (st.wake_cnt == 8'h00)
            begin
                nx.waking = 1'b0;
                wake_done = 1'b1;
            end
            else
                nx.wake_cnt = st.wake_cnt - 8'h01;
        end

        // Interrupt sources; noise contributes nothing of its own
        rx_evt  = push & (!st.ctrl_two[C2_ADDR_DETECT_ENABLE] | top_bit);
        any_evt = (st.ctrl_two[C2_RIE] & (rx_evt | ovr_set | wake_done))
                | (st.ctrl_two[C2_TEIE] & tx_buf_empty & !st.tx_empty_prev)
                | (st.ctrl_two[C2_TIIE] & tx_idle & !st.tx_idle_prev);
        nx.irq_n = !(st.irqctl[IC_GIE] & st.irqctl[IC_UIE] & any_evt);
    end

    // Only presetn clears state; sleep has no path into it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st          <= '0;
            st.rx_st    <= ST_IDLE;
            st.baud     <= BAUD_RST;
            st.rx_prev  <= 1'b1;
            st.irq_n    <= 1'b1;
        end
        else
            st <= nx;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("APB ready not one cycle after setup");
    par_off_a: assert property (push && !st.ctrl_one[C1_PEN]
                                |=> !st.fifo[$past(tail)].parity_error_flag)
        else $error("Parity error flagged with parity off");
    status_ro_a: assert property (apb_acc && pwrite && !ovr_set && !push
                                  |=> st.overrun == $past(st.overrun)
                                  && st.count == $past(st.count))
        else $error("Write changed status flags");
    rdy_clear_a: assert property (seq_clear && st.count == 2'h1 && !push
                                  |=> st.count == 2'h0)
        else $error("Sequence did not clear data ready");
    plain_irq_a: assert property (push && !st.ctrl_two[C2_ADDR_DETECT_ENABLE] && st.ctrl_two[C2_RIE]
                                  && (&st.irqctl) |=> !uart_irq_n)
        else $error("Word without address detect did not interrupt");
    clk_pause_a: assert property (!uart_clk_on && rx_enabled && st.rx_st != ST_IDLE
                                  |=> st.rx_st == $past(st.rx_st)
                                  && st.os_cnt == $past(st.os_cnt))
        else $error("Receiver moved while clock stopped");
    overrun_set_a: assert property (frame_done && st.count == 2'h2 && !pop |=> st.overrun)
        else $error("Third word on full buffer did not set overrun");
    keep_buffer_a: assert property (frame_done && st.count == 2'h2 && !pop
                                    |=> st.fifo == $past(st.fifo))
        else $error("Buffer changed on overrun");
    ovr_irq_a: assert property (ovr_set && st.ctrl_two[C2_RIE] && (&st.irqctl)
                                |=> !uart_irq_n)
        else $error("Overrun did not interrupt");
    ovr_clear_a: assert property (seq_clear && !ovr_set |=> !st.overrun)
        else $error("Sequence did not clear overrun");
    noise_flag_a: assert property (push && st.count == 2'h0 && nf_in
                                   |=> st.fifo[st.head].nf && st.count == 2'h1)
        else $error("Noisy word not flagged");
    irq_cause_a: assert property (!uart_irq_n |-> $past(any_evt))
        else $error("Interrupt without a source");
    framing_error_flag_store_a: assert property (push && st.count == 2'h0 && fe_in
                                   |=> st.fifo[st.head].framing_error_flag)
        else $error("Framing error not stored");
    addr_mask_a: assert property (push && st.ctrl_two[C2_ADDR_DETECT_ENABLE] && !top_bit
                                  && !ovr_set && !wake_done && !(st.ctrl_two[C2_TEIE]
                                  || st.ctrl_two[C2_TIIE]) |=> uart_irq_n)
        else $error("Address detect let data interrupt");
    wake_pulse_a: assert property (wake_trig |=> wake_req && st.waking
                                   ##1 !wake_req)
        else $error("Wake-up not signalled");
    wake_ignore_a: assert property (st.waking |=> st.rx_st == ST_IDLE)
        else $error("Data taken during restart delay");
    wake_gate_a: assert property (wake_done && !st.irqctl[IC_GIE] |=> uart_irq_n)
        else $error("Gated wake-up raised interrupt");

    push_c: cover property (push ##[1:200] pop);
    overrun_c: cover property (ovr_set);
    wake_c: cover property (wake_trig ##[1:120] wake_done);
    addr_irq_c: cover property (push && st.ctrl_two[C2_ADDR_DETECT_ENABLE] && top_bit ##1 !uart_irq_n);
endmodule

// *** testbench/urx_tx_model.sv ***
`timescale 1ns/100ps
module urx_tx_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic pclk,
    output logic      rxd
);
    initial rxd = 1'b1;

    // One bit time, optionally with a one-cycle glitch near the bit centre
    task automatic bit_out(input logic v, input logic glitch);
        rxd <= v;
        repeat (8) @(posedge pclk);
        if (glitch)
            rxd <= ~v;
        @(posedge pclk);
        rxd <= v;
        repeat (BIT_CYC - 9) @(posedge pclk);
    endtask

    // Start bit, data LSB first, optional parity, stop bits, one idle bit
    task automatic send(input logic [8:0] w, input int nb, input logic has_par,
                        input logic pbit, input logic [1:0] st, input int ns,
                        input logic noisy);
        @(posedge pclk);
        bit_out(1'b0, 1'b0);
        for (int i = 0; i < nb; i++)
            bit_out(w[i], noisy && i == 1);
        if (has_par)
            bit_out(pbit, 1'b0);
        for (int i = 0; i < ns; i++)
            bit_out(st[i], 1'b0);
        bit_out(1'b1, 1'b0);
    endtask

    // Bare low pulse on an idle line
    task automatic pulse(input int n);
        @(posedge pclk);
        rxd <= 1'b0;
        repeat (n) @(posedge pclk);
        rxd <= 1'b1;
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
    import urx_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        uart_clk_on = 1'b1;
    logic        tx_buf_empty = 1'b0;
    logic        tx_idle = 1'b0;
    logic        uart_irq_n;
    logic        wake_req;
    logic [31:0] rdat;
    logic        serr;
    int          errors = 0;
    int          tests_run = 0;
    int          irq_cnt = 0;
    int          wake_cnt = 0;

    urx_rx_err DUT (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .rxd          (rxd),
        .uart_clk_on  (uart_clk_on),
        .tx_buf_empty (tx_buf_empty),
        .tx_idle      (tx_idle),
        .uart_irq_n   (uart_irq_n),
        .wake_req     (wake_req)
    );

    urx_tx_model #(.BIT_CYC(16)) tx (
        .pclk (pclk),
        .rxd  (rxd)
    );

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        irq_cnt <= irq_cnt + int'(uart_irq_n === 1'b0);
        wake_cnt <= wake_cnt + int'(wake_req === 1'b1);
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            errors++;
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] m,
                           input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rdat & m, exp);
    endtask

    // Status access, then data read of the head word
    task automatic pop(input logic [8:0] exp);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk_reg("pop_data", ADDR_DATA, 32'h000001FF, {23'h0, exp});
    endtask

    task automatic t_regs();
        chk_reg("rst_status", ADDR_STATUS, 32'hFFFFFFEF, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h000000FF);
        chk_reg("status_ro", ADDR_STATUS, 32'hFFFFFFEF, 32'h0);
        chk_reg("rst_baud", ADDR_BAUD, 32'hFFFFFFFF, {24'h0, BAUD_RST});
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped_err", {31'h0, serr}, 32'h1);
        $display("t_regs done");
    endtask

    task automatic t_tx_irq();
        int base;
        apb(1'b1, ADDR_IRQCTL, 32'h3);
        apb(1'b1, ADDR_CTRL_TWO, 32'h08);
        base = irq_cnt;
        tx_idle <= 1'b1;
        repeat (5) @(posedge pclk);
        check("idle_masked", irq_cnt - base, 0);
        tx_buf_empty <= 1'b1;
        repeat (5) @(posedge pclk);
        check("empty_irq", irq_cnt - base, 1);
        tx_idle <= 1'b0;
        apb(1'b1, ADDR_CTRL_TWO, 32'h10);
        tx_idle <= 1'b1;
        repeat (5) @(posedge pclk);
        check("idle_irq", irq_cnt - base, 2);
        $display("t_tx_irq done");
    endtask

    task automatic t_noise();
        int base;
        apb(1'b0, ADDR_DATA, 32'h0);
        apb(1'b1, ADDR_CTRL_ONE, 32'h01);
        apb(1'b1, ADDR_CTRL_TWO, 32'h05);
        base = irq_cnt;
        tx.send(9'h0A5, 8, 1'b0, 1'b0, 2'b11, 1, 1'b1);
        check("noisy_irq", irq_cnt - base, 1);
        chk_reg("no_arm_data", ADDR_DATA, 32'h1FF, 32'hA5);
        chk_reg("noise_rdy", ADDR_STATUS, 32'h2F, 32'h24);
        chk_reg("noise_data", ADDR_DATA, 32'h1FF, 32'hA5);
        chk_reg("noise_clr", ADDR_STATUS, 32'h2F, 32'h00);
        $display("t_noise done");
    endtask

    task automatic t_overrun();
        int base;
        tx.send(9'h011, 8, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        tx.send(9'h022, 8, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        base = irq_cnt;
        tx.send(9'h033, 8, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        check("ovr_irq", irq_cnt - base, 1);
        chk_reg("ovr_flag", ADDR_STATUS, 32'h2F, 32'h28);
        chk_reg("ovr_head", ADDR_DATA, 32'h1FF, 32'h11);
        chk_reg("ovr_clr", ADDR_STATUS, 32'h2F, 32'h20);
        chk_reg("ovr_next", ADDR_DATA, 32'h1FF, 32'h22);
        chk_reg("ovr_empty", ADDR_STATUS, 32'h2F, 32'h00);
        $display("t_overrun done");
    endtask

    task automatic t_errors();
        apb(1'b1, ADDR_CTRL_ONE, 32'h15);
        tx.send(9'h003, 8, 1'b1, 1'b1, 2'b01, 2, 1'b0);
        tx.send(9'h001, 8, 1'b1, 1'b1, 2'b11, 2, 1'b0);
        chk_reg("err_flags", ADDR_STATUS, 32'h2F, 32'h23);
        chk_reg("err_data", ADDR_DATA, 32'h1FF, 32'h03);
        chk_reg("clean_flags", ADDR_STATUS, 32'h2F, 32'h20);
        chk_reg("clean_data", ADDR_DATA, 32'h1FF, 32'h01);
        apb(1'b1, ADDR_CTRL_ONE, 32'h0D);
        tx.send(9'h001, 8, 1'b1, 1'b1, 2'b11, 1, 1'b0);
        chk_reg("odd_flags", ADDR_STATUS, 32'h2F, 32'h21);
        pop(9'h001);
        $display("t_errors done");
    endtask

    task automatic t_addr();
        int base;
        apb(1'b1, ADDR_CTRL_ONE, 32'h03);
        apb(1'b1, ADDR_CTRL_TWO, 32'h07);
        base = irq_cnt;
        tx.send(9'h0FF, 9, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        check("addr9_low", irq_cnt - base, 0);
        tx.send(9'h155, 9, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        check("addr9_high", irq_cnt - base, 1);
        chk_reg("ninth_low", ADDR_CTRL_ONE, 32'h20, 32'h00);
        pop(9'h0FF);
        chk_reg("ninth_high", ADDR_CTRL_ONE, 32'h20, 32'h20);
        pop(9'h155);
        apb(1'b1, ADDR_CTRL_ONE, 32'h01);
        tx.send(9'h07F, 8, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        check("addr8_low", irq_cnt - base, 1);
        tx.send(9'h080, 8, 1'b0, 1'b0, 2'b11, 1, 1'b0);
        check("addr8_high", irq_cnt - base, 2);
        pop(9'h07F);
        pop(9'h080);
        $display("t_addr done");
    endtask

    task automatic t_wake();
        int base;
        int wb;
        apb(1'b1, ADDR_CTRL_TWO, 32'h25);
        for (int g = 0; g < 2; g++)
        begin
            apb(1'b1, ADDR_IRQCTL, 32'(3 * g));
            base = irq_cnt;
            wb = wake_cnt;
            uart_clk_on <= 1'b0;
            tx.pulse(30);
            uart_clk_on <= 1'b1;
            check("wake_pulse", wake_cnt - wb, 1);
            repeat (40) @(posedge pclk);
            check("wake_early", irq_cnt - base, 0);
            repeat (100) @(posedge pclk);
            check("wake_irq", irq_cnt - base, 32'(g));
            chk_reg("wake_ignored", ADDR_STATUS, 32'h20, 32'h00);
        end
        $display("t_wake done");
    endtask

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_tx_irq();
        t_noise();
        t_overrun();
        t_errors();
        t_addr();
        t_wake();
        final_report();
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        errors++;
        final_report();
    end
endmodule
